// [efr_pkg.sv]
package efr_pkg;
   localparam int WORD_W = 32;
   localparam int DATA_W = 24;
   localparam int ADDR_W = 7;
   localparam int HS_W = 16;
   localparam int RW_BIT = 31;
   localparam int ADDR_HI = 30;
   localparam int ADDR_LO = 24;
   localparam int DATA_HI = 23;
   localparam int RATE_LSB = 0;
   localparam logic [1:0] RATE_HIGH = 2'h3;

   localparam logic [6:0] A_NOP = 7'h00;
   localparam logic [6:0] A_ACQ = 7'h01;
   localparam logic [6:0] A_LEAD_OFF_STATUS = 7'h02;
   localparam logic [6:0] A_RESP = 7'h03;
   localparam logic [6:0] A_PACE = 7'h04;
   localparam logic [6:0] A_CMREF = 7'h05;
   localparam logic [6:0] A_PIO = 7'h06;
   localparam logic [6:0] A_PAMP = 7'h07;
   localparam logic [6:0] A_TONE = 7'h08;
   localparam logic [6:0] A_CDAC = 7'h09;
   localparam logic [6:0] A_FRM = 7'h0a;
   localparam logic [6:0] A_FILT = 7'h0b;
   localparam logic [6:0] A_LUTH = 7'h0c;
   localparam logic [6:0] A_LLTH = 7'h0d;
   localparam logic [6:0] A_PEDG = 7'h0e;
   localparam logic [6:0] A_PLVL = 7'h0f;
   localparam logic [6:0] A_CH1 = 7'h11;
   localparam logic [6:0] A_CH2 = 7'h12;
   localparam logic [6:0] A_CH3 = 7'h13;
   localparam logic [6:0] A_PRES = 7'h1a;
   localparam logic [6:0] A_RMAG = 7'h1b;
   localparam logic [6:0] A_RPH = 7'h1c;
   localparam logic [6:0] A_LST = 7'h1d;
   localparam logic [6:0] A_DCL = 7'h1e;
   localparam logic [6:0] A_OPS = 7'h1f;
   localparam logic [6:0] A_GC1 = 7'h21;
   localparam logic [6:0] A_GC3 = 7'h23;
   localparam logic [6:0] A_LA1 = 7'h31;
   localparam logic [6:0] A_LA3 = 7'h33;
   localparam logic [6:0] A_PM1 = 7'h3a;
   localparam logic [6:0] A_PM3 = 7'h3c;
   localparam logic [6:0] A_HDR = 7'h40;
   localparam logic [6:0] A_CRC = 7'h41;

   localparam logic [23:0] RST_ZERO = 24'h00_0000;
   localparam logic [23:0] RST_PACE = 24'h00_0f88;
   localparam logic [23:0] RST_CMREF = 24'he0_0000;
   localparam logic [23:0] RST_PAMP = 24'h24_2424;
   localparam logic [23:0] RST_CDAC = 24'h00_2000;
   localparam logic [23:0] RST_FRM = 24'h07_9000;
   localparam logic [23:0] RST_LUTH = 24'h00_ffff;
   localparam logic [23:0] RST_HDR = 24'h80_0000;
   localparam logic [23:0] RST_CRC = 24'hff_ffff;

   typedef struct packed {
      logic rw;
      logic [6:0] addr;
      logic [23:0] data;
   } efr_cmd_t;

   typedef struct packed {
      logic [23:0] ch1;
      logic [23:0] ch2;
      logic [23:0] ch3;
   } efr_trio_t;
endpackage : efr_pkg

// [efr_cfg_mem.sv]
// sixteen-word control store, read data registered
module efr_cfg_mem (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic wr_en_in,
   input wire logic [3:0] wr_idx_in,
   input wire logic [23:0] wr_data_in,
   input wire logic [3:0] rd_idx_in,
   output logic [23:0] rd_data_out,
   output logic [23:0] frame_ctl_out,
   output logic [23:0] acq_ctl_out
);
   logic [23:0] mem_reg [16];

   function automatic logic [23:0] rst_val(input logic [3:0] i);
      unique case (i)
         efr_pkg::A_PACE[3:0]: rst_val = efr_pkg::RST_PACE;
         efr_pkg::A_CMREF[3:0]: rst_val = efr_pkg::RST_CMREF;
         efr_pkg::A_PAMP[3:0]: rst_val = efr_pkg::RST_PAMP;
         efr_pkg::A_CDAC[3:0]: rst_val = efr_pkg::RST_CDAC;
         efr_pkg::A_FRM[3:0]: rst_val = efr_pkg::RST_FRM;
         efr_pkg::A_LUTH[3:0]: rst_val = efr_pkg::RST_LUTH;
         default: rst_val = efr_pkg::RST_ZERO;
      endcase
   endfunction : rst_val

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         for (int i = 0; i < 16; i++) begin
            mem_reg[i] <= rst_val(4'(i));
         end
      end else if (wr_en_in && wr_idx_in != 4'h0) begin
         // slot zero is the no-op word and never stores
         mem_reg[wr_idx_in] <= wr_data_in;
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rd_data_out <= efr_pkg::RST_ZERO;
      end else if (wr_en_in && wr_idx_in == rd_idx_in && wr_idx_in != 4'h0) begin
         // a write is answered with its new value, so pass it straight through
         rd_data_out <= wr_data_in;
      end else begin
         rd_data_out <= mem_reg[rd_idx_in];
      end
   end

   assign frame_ctl_out = mem_reg[efr_pkg::A_FRM[3:0]];
   assign acq_ctl_out = mem_reg[efr_pkg::A_ACQ[3:0]];
endmodule : efr_cfg_mem

// [efr_regmap.sv]
module efr_regmap #(
   parameter bit FULL_VARIANT = 1'b1
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic cmd_valid_in,
   input wire logic [31:0] cmd_word_in,
   input wire logic sample_valid_in,
   input wire efr_pkg::efr_trio_t sample_in,
   input wire efr_pkg::efr_trio_t lead_amp_in,
   input wire logic [23:0] resp_mag_in,
   input wire logic [23:0] resp_phase_in,
   input wire logic [23:0] pace_result_in,
   input wire efr_pkg::efr_trio_t pace_meas_in,
   input wire logic [23:0] lead_off_in,
   input wire logic [23:0] dc_lead_off_in,
   input wire logic [23:0] op_state_in,
   input wire logic [23:0] header_in,
   input wire logic [23:0] checksum_in,
   output logic rd_valid_out,
   output logic [31:0] rd_word_out,
   output logic hs_word_valid_out,
   output logic [15:0] hs_word_out,
   output logic [23:0] frame_ctl_out,
   output logic [23:0] acq_ctl_out
);
   efr_pkg::efr_cmd_t cmd;
   efr_pkg::efr_trio_t gain_reg;
   efr_pkg::efr_trio_t samp_reg;
   logic [23:0] mag_reg;
   logic [23:0] ph_reg;
   logic [23:0] mem_rd;
   logic [23:0] frame_ctl;
   logic [23:0] acq_ctl;
   logic rd_pend_reg;
   logic [6:0] rd_addr_reg;
   logic [23:0] ro_data;
   logic is_cfg;
   logic is_gain;

   assign cmd = efr_pkg::efr_cmd_t'(cmd_word_in);
   assign is_cfg = cmd.addr[6:4] == 3'h0;
   assign is_gain = cmd.addr >= efr_pkg::A_GC1 && cmd.addr <= efr_pkg::A_GC3;

   function automatic logic [1:0] idx3(input logic [6:0] a);
      idx3 = 2'(a[1:0] - 2'h1);
   endfunction : idx3

   function automatic logic [23:0] pick(input efr_pkg::efr_trio_t t, input logic [1:0] i);
      unique case (i)
         2'h0: pick = t.ch1;
         2'h1: pick = t.ch2;
         default: pick = t.ch3;
      endcase
   endfunction : pick

   // reduced variant keeps no respiration storage and, of the pace words, keeps only A_PACE
   function automatic logic feat_ok(input logic [6:0] a);
      feat_ok = FULL_VARIANT || !(a == efr_pkg::A_RESP || a == efr_pkg::A_PAMP
         || a == efr_pkg::A_PEDG || a == efr_pkg::A_PLVL);
   endfunction : feat_ok

   efr_cfg_mem u_cfg (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .wr_en_in(cmd_valid_in && cmd.rw && is_cfg && feat_ok(cmd.addr)),
      .wr_idx_in(cmd.addr[3:0]),
      .wr_data_in(cmd.data),
      .rd_idx_in(cmd.addr[3:0]),
      .rd_data_out(mem_rd),
      .frame_ctl_out(frame_ctl),
      .acq_ctl_out(acq_ctl)
   );

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         gain_reg <= '0;
      end else if (cmd_valid_in && cmd.rw && is_gain) begin
         unique case (idx3(cmd.addr))
            2'h0: gain_reg.ch1 <= cmd.data;
            2'h1: gain_reg.ch2 <= cmd.data;
            default: gain_reg.ch3 <= cmd.data;
         endcase
      end
   end

   // read-only words only follow the datapath; host writes land nowhere
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         samp_reg <= '0;
         mag_reg <= efr_pkg::RST_ZERO;
         ph_reg <= efr_pkg::RST_ZERO;
      end else if (sample_valid_in) begin
         samp_reg <= sample_in;
         mag_reg <= FULL_VARIANT ? resp_mag_in : efr_pkg::RST_ZERO;
         ph_reg <= FULL_VARIANT ? resp_phase_in : efr_pkg::RST_ZERO;
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rd_pend_reg <= 1'b0;
         rd_addr_reg <= efr_pkg::A_NOP;
      end else begin
         // a write is answered too, echoing the read-back of its address
         rd_pend_reg <= cmd_valid_in;
         if (cmd_valid_in) begin
            rd_addr_reg <= cmd.addr;
         end
      end
   end

   always_comb begin
      ro_data = efr_pkg::RST_ZERO; // unassigned space reads zero
      unique case (rd_addr_reg) inside
         efr_pkg::A_NOP: ro_data = efr_pkg::RST_ZERO;
         [efr_pkg::A_ACQ:efr_pkg::A_PLVL]: ro_data = feat_ok(rd_addr_reg) ? mem_rd : '0;
         [efr_pkg::A_CH1:efr_pkg::A_CH3]: ro_data = pick(samp_reg, idx3(rd_addr_reg));
         efr_pkg::A_PRES: ro_data = FULL_VARIANT ? pace_result_in : '0;
         efr_pkg::A_RMAG: ro_data = mag_reg;
         efr_pkg::A_RPH: ro_data = ph_reg;
         efr_pkg::A_LST: ro_data = lead_off_in;
         efr_pkg::A_DCL: ro_data = dc_lead_off_in;
         efr_pkg::A_OPS: ro_data = op_state_in;
         [efr_pkg::A_GC1:efr_pkg::A_GC3]: ro_data = pick(gain_reg, idx3(rd_addr_reg));
         [efr_pkg::A_LA1:efr_pkg::A_LA3]: ro_data = pick(lead_amp_in, idx3(rd_addr_reg));
         [efr_pkg::A_PM1:efr_pkg::A_PM3]: begin
            ro_data = FULL_VARIANT ? pick(pace_meas_in, 2'(rd_addr_reg - efr_pkg::A_PM1)) : '0;
         end
         efr_pkg::A_HDR: ro_data = header_in;
         efr_pkg::A_CRC: ro_data = checksum_in;
         default: ro_data = efr_pkg::RST_ZERO; // reserved space is the host's fault
      endcase
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rd_valid_out <= 1'b0;
         rd_word_out <= 32'h0000_0000;
         hs_word_valid_out <= 1'b0;
         hs_word_out <= 16'h0000;
      end else begin
         rd_valid_out <= rd_pend_reg;
         hs_word_valid_out <= rd_pend_reg
            && frame_ctl[efr_pkg::RATE_LSB +: 2] == efr_pkg::RATE_HIGH;
         // answer words hold until the next answer, the idle bus is never echoed
         if (rd_pend_reg) begin
            rd_word_out <= {1'b0, rd_addr_reg, ro_data};
            hs_word_out <= ro_data[23:8]; // upper 16 bits, no identifier
         end
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         frame_ctl_out <= efr_pkg::RST_FRM;
         acq_ctl_out <= efr_pkg::RST_ZERO;
      end else begin
         frame_ctl_out <= frame_ctl;
         acq_ctl_out <= acq_ctl;
      end
   end
endmodule : efr_regmap

// [efr_regmap_sva.sv]
module efr_regmap_sva (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic cmd_valid_in,
   input wire logic [31:0] cmd_word_in,
   input wire logic rd_valid_out,
   input wire logic [31:0] rd_word_out,
   input wire logic hs_word_valid_out,
   input wire logic [23:0] frame_ctl_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);
   sequence s_wr(logic [6:0] a);
      cmd_valid_in && cmd_word_in[31] && cmd_word_in[30:24] == a;
   endsequence
   sequence s_ans;
      ##2 rd_valid_out;
   endsequence
   a_answer_delay: assert property (cmd_valid_in |-> s_ans)
      else $error("answer missing");
   a_answer_cause: assert property (rd_valid_out |-> $past(cmd_valid_in, 2))
      else $error("answer without command");
   a_addr_echo: assert property (cmd_valid_in |-> s_ans ##0
      rd_word_out[30:24] == $past(cmd_word_in[30:24], 2)) else $error("address wrong");
   a_flag_clear: assert property (rd_valid_out |-> !rd_word_out[31])
      else $error("flag set in answer");
   a_nop_zero: assert property (cmd_valid_in && cmd_word_in[30:24] == 7'h00
      |-> ##2 rd_word_out[23:0] == 24'h00_0000) else $error("nop not zero");
   a_rw_echo: assert property (cmd_valid_in && cmd_word_in[31] && cmd_word_in[30:24]
      inside {[7'h01:7'h0f], [7'h21:7'h23]} |-> ##2 rd_word_out[23:0] ==
      $past(cmd_word_in[23:0], 2)) else $error("write not stored");
   a_frame_copy: assert property (s_wr(7'h0a) |-> ##2 frame_ctl_out ==
      $past(cmd_word_in[23:0], 2)) else $error("frame copy stale");
   a_rate_gate: assert property (hs_word_valid_out |-> frame_ctl_out[1:0] == 2'h3
      || $past(frame_ctl_out[1:0]) == 2'h3) else $error("short word at low rate");
endmodule : efr_regmap_sva
bind efr_regmap efr_regmap_sva u_sva (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
   .cmd_valid_in(cmd_valid_in), .cmd_word_in(cmd_word_in), .rd_valid_out(rd_valid_out),
   .rd_word_out(rd_word_out), .hs_word_valid_out(hs_word_valid_out),
   .frame_ctl_out(frame_ctl_out));

// [efr_host_model.sv]
module efr_host_model (
   input wire logic clk_in,
   input wire logic rd_valid_in,
   input wire logic [31:0] rd_word_in,
   output logic cmd_valid_out,
   output logic [31:0] cmd_word_out
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      cmd_valid_out = 1'b0;
      cmd_word_out = 32'h0000_0000;
   end
   // one command, then wait a bounded time for its answer
   task automatic xfer(input efr_pkg::efr_cmd_t c, output logic [31:0] r);
      bit ok;
      ok = 1'b0;
      @(posedge clk_in);
      #1 cmd_valid_out = 1'b1;
      cmd_word_out = c;
      @(posedge clk_in);
      #1 cmd_valid_out = 1'b0;
      cmd_word_out = ~c; // released word must not look valid
      for (int n = 0; n < 8 && !ok; n++) begin
         @(posedge clk_in);
         #1 ok = (rd_valid_in === 1'b1);
      end
      r = ok ? rd_word_in : 32'hxxxx_xxxx;
   endtask : xfer
endmodule : efr_host_model

// [efr_regmap_tb_top.sv]
module efr_regmap_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic sv = 1'b0;
   logic cmd_valid, rd_valid, hs_valid;
   logic [31:0] cmd_word, rd_word, r;
   logic [15:0] hs_word;
   logic [23:0] fctl, actl, rmag_in, rph_in, rmag, rph, pres, lst, dcl, ops, hdr, crc;
   efr_pkg::efr_trio_t smp_in, smp, lamp, pmeas;
   logic [23:0] mir [0:127];
   int n_fail = 0;
   int comparisons = 0;
   always #2.5 clk_in = ~clk_in;
   efr_regmap #(.FULL_VARIANT(1'b1)) dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .cmd_valid_in(cmd_valid), .cmd_word_in(cmd_word), .sample_valid_in(sv),
      .sample_in(smp_in), .lead_amp_in(lamp), .resp_mag_in(rmag_in), .resp_phase_in(rph_in),
      .pace_result_in(pres), .pace_meas_in(pmeas), .lead_off_in(lst), .dc_lead_off_in(dcl),
      .op_state_in(ops), .header_in(hdr), .checksum_in(crc), .rd_valid_out(rd_valid),
      .rd_word_out(rd_word), .hs_word_valid_out(hs_valid), .hs_word_out(hs_word),
      .frame_ctl_out(fctl), .acq_ctl_out(actl));
   efr_host_model host (.clk_in(clk_in), .rd_valid_in(rd_valid), .rd_word_in(rd_word),
      .cmd_valid_out(cmd_valid), .cmd_word_out(cmd_word));
   function automatic bit mapped(input logic [6:0] a);
      return a inside {[7'h00:7'h0f], [7'h11:7'h13], [7'h1a:7'h1f], [7'h21:7'h23],
         [7'h31:7'h33], [7'h3a:7'h3c], 7'h40, 7'h41};
   endfunction : mapped
   function automatic logic [23:0] exp_rd(input logic [6:0] a);
      case (a)
         7'h11, 7'h12, 7'h13: return smp[95 - 24 * a[1:0] -: 24];
         7'h1a: return pres;
         7'h1b: return rmag;
         7'h1c: return rph;
         7'h1d: return lst;
         7'h1e: return dcl;
         7'h1f: return ops;
         7'h31, 7'h32, 7'h33: return lamp[95 - 24 * a[1:0] -: 24];
         7'h3a, 7'h3b, 7'h3c: return pmeas[95 - 24 * (a - 7'h39) -: 24];
         7'h40: return hdr;
         7'h41: return crc;
         default: return mir[a];
      endcase
   endfunction : exp_rd
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_short(input logic [16:0] got, input logic [16:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: short word got %h want %h", $time, got, exp);
      end
   endtask : chk_short
   task automatic chk_ctl(input logic [47:0] got, input logic [47:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: control copy got %h want %h", $time, got, exp);
      end
   endtask : chk_ctl
   task automatic run_cmd(input logic rw, input logic [6:0] a, input logic [23:0] d);
      logic [23:0] e;
      host.xfer('{rw, a, d}, r);
      if (rw && a inside {[7'h01:7'h0f], [7'h21:7'h23]}) mir[a] = d;
      e = exp_rd(a);
      chk(r, {1'b0, a, e});
      chk_short({hs_valid, hs_word}, {mir[10][1:0] == 2'h3, e[23:8]});
      chk_ctl({fctl, actl}, {mir[10], mir[1]});
   endtask : run_cmd
   task automatic give_verdict();
      $display("comparisons %0d, n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   initial begin
      logic [6:0] a;
      void'($urandom(32'hcfb1_5d9a));
      {lamp, pmeas, smp_in, hdr, crc, rmag_in} = {$urandom, $urandom, $urandom, $urandom,
         $urandom, $urandom, $urandom, $urandom, $urandom};
      {pres, lst, dcl, ops} = {$urandom, $urandom, $urandom};
      rph_in = ~rmag_in;
      {smp, rmag, rph} = 120'h0;
      for (int i = 0; i < 128; i++) mir[i] = 24'h00_0000;
      mir[4] = 24'h00_0f88;
      mir[5] = 24'he0_0000;
      mir[7] = 24'h24_2424;
      mir[9] = 24'h00_2000;
      mir[10] = 24'h07_9000;
      mir[12] = 24'h00_ffff;
      repeat (12) @(posedge clk_in);
      #1 sys_rst_in = 1'b0;
      for (a = 7'h00; a < 7'h42; a++) if (mapped(a)) run_cmd(1'b0, a, 24'h00_0000);
      $display("reset sweep done");
      run_cmd(1'b1, 7'h00, 24'hff_ffff);
      run_cmd(1'b1, 7'h31, 24'h12_3456);
      run_cmd(1'b1, 7'h1b, 24'h65_4321);
      run_cmd(1'b1, 7'h0a, 24'h07_9003);
      run_cmd(1'b0, 7'h0a, 24'h00_0000);
      $display("corner cases done");
      repeat (300) begin
         if ($urandom_range(3, 0) == 0) begin
            @(posedge clk_in);
            #1 sv = 1'b1;
            @(posedge clk_in);
            #1 sv = 1'b0;
            {smp, rmag, rph} = {smp_in, rmag_in, rph_in};
            smp_in = {$urandom, $urandom, 8'($urandom)};
            rmag_in = 24'($urandom);
            rph_in = 24'($urandom);
         end
         do a = 7'($urandom); while (!mapped(a));
         run_cmd(1'($urandom), a, 24'($urandom));
      end
      $display("random traffic done");
      give_verdict();
   end
   initial begin
      #100000;
      n_fail++;
      give_verdict();
   end
endmodule : efr_regmap_tb_top
